// *** rtl/pdpc_pkg.sv ***
// Constants and types for the synthesizer configuration field bank
package pdpc_pkg;

  // ----------------------------------------
  // Register indices (byte address is four times)
  // ----------------------------------------
  localparam logic [7:0] IDX_POWER = 8'h02;
  localparam logic [7:0] IDX_FB_LOW = 8'h10;
  localparam logic [7:0] IDX_FB_MID = 8'h11;
  localparam logic [7:0] IDX_FB_HIGH_MOD = 8'h12;
  localparam logic [7:0] IDX_NUM0 = 8'h13;
  localparam logic [7:0] IDX_NUM1 = 8'h14;
  localparam logic [7:0] IDX_NUM2 = 8'h15;
  localparam logic [7:0] IDX_DEN0 = 8'h16;
  localparam logic [7:0] IDX_DEN1 = 8'h17;
  localparam logic [7:0] IDX_DEN2 = 8'h18;
  localparam logic [7:0] IDX_REF_LOW = 8'h19;
  localparam logic [7:0] IDX_REF_HIGH = 8'h1a;
  localparam logic [7:0] IDX_REF_OPT = 8'h1b;
  localparam logic [7:0] IDX_PUMP = 8'h1c;
  // Own control/status registers
  localparam logic [7:0] IDX_RAMP_CTRL = 8'h20;
  localparam logic [7:0] IDX_STATUS = 8'h21;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int PWR_SEL_LSB = 0;
  localparam int SOFT_RST_BIT = 2;
  localparam int FB_HIGH_LSB = 0;
  localparam int DITHER_LSB = 2;
  localparam int ORDER_LSB = 4;
  localparam int DOUBLER_BIT = 0;
  localparam int STYLE_BIT = 2;
  localparam int MIN_PULSE_LSB = 3;
  localparam int GAIN_LSB = 0;
  localparam int POL_BIT = 5;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_POWER = 8'h00;
  localparam logic [7:0] RST_FB_LOW = 8'h10;
  localparam logic [7:0] RST_FB_MID = 8'h00;
  localparam logic [7:0] RST_FB_HIGH_MOD = 8'h00;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_REF_LOW = 8'h01;
  localparam logic [7:0] RST_REF_OPT = 8'h08;
  localparam logic [7:0] RST_PUMP = 8'h00;

  localparam logic [24:0] FIXED_DEN = 25'h100_0000;
  localparam logic [7:0] REG_COUNT = 8'h10;

  typedef enum logic [1:0] {
    PDPC_PWR_DOWN,
    PDPC_PWR_UP,
    PDPC_PWR_PIN,
    PDPC_PWR_RSVD
  } pdpc_power_e;

  // Decoded analog-side configuration
  typedef struct packed {
    logic powered;
    logic [17:0] feedback_div;
    logic [1:0] modulator_dither;
    logic [2:0] modulator_order;
    logic order_reserved;
    logic [23:0] fraction_numerator;
    logic [24:0] fraction_denominator;
    logic [15:0] reference_div;
    logic reference_bypass;
    logic reference_doubler_enable;
    logic reference_divider_style;
    logic [1:0] pump_min_pulse;
    logic pump_tristate;
    logic [11:0] pump_current_ua;
    logic pump_polarity;
  } pdpc_cfg_s;

endpackage

// *** rtl/pdpc_bank.sv ***
// APB register bank for the synthesizer divider, modulator and pump fields
`timescale 1ns/1ps
`default_nettype none
module pdpc_bank (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic chip_enable,
  output pdpc_pkg::pdpc_cfg_s cfg,
  output logic ramp_start,
  output logic ramp_enable
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  // Only the fourteen programmable bytes are stored; own control and status live in flops
  logic [7:0] regs [0:13];
  logic ramp_en_reg;
  logic ramp_start_reg;
  logic soft_rst_seen_reg;

  function automatic logic [4:0] idx_of(input logic [11:0] a);
    logic [9:0] w;
    w = a[11:2];
    // Misaligned or beyond the 8-bit index space never aliases onto a register
    if (a[1:0] != 2'b00 || w[9:8] != 2'b00) begin
      return 5'h1f;
    end
    unique case (w[7:0])
      pdpc_pkg::IDX_POWER: return 5'd0;
      pdpc_pkg::IDX_FB_LOW: return 5'd1;
      pdpc_pkg::IDX_FB_MID: return 5'd2;
      pdpc_pkg::IDX_FB_HIGH_MOD: return 5'd3;
      pdpc_pkg::IDX_NUM0: return 5'd4;
      pdpc_pkg::IDX_NUM1: return 5'd5;
      pdpc_pkg::IDX_NUM2: return 5'd6;
      pdpc_pkg::IDX_DEN0: return 5'd7;
      pdpc_pkg::IDX_DEN1: return 5'd8;
      pdpc_pkg::IDX_DEN2: return 5'd9;
      pdpc_pkg::IDX_REF_LOW: return 5'd10;
      pdpc_pkg::IDX_REF_HIGH: return 5'd11;
      pdpc_pkg::IDX_REF_OPT: return 5'd12;
      pdpc_pkg::IDX_PUMP: return 5'd13;
      pdpc_pkg::IDX_RAMP_CTRL: return 5'd14;
      pdpc_pkg::IDX_STATUS: return 5'd15;
      default: return 5'h1f;
    endcase
  endfunction

  function automatic logic [7:0] reset_of(input int i);
    unique case (i)
      0: return pdpc_pkg::RST_POWER;
      1: return pdpc_pkg::RST_FB_LOW;
      2: return pdpc_pkg::RST_FB_MID;
      3: return pdpc_pkg::RST_FB_HIGH_MOD;
      10: return pdpc_pkg::RST_REF_LOW;
      12: return pdpc_pkg::RST_REF_OPT;
      13: return pdpc_pkg::RST_PUMP;
      default: return pdpc_pkg::RST_ZERO;
    endcase
  endfunction

  logic [4:0] sel_idx;
  logic in_range;
  logic access;
  logic wr_en;
  logic soft_rst_req;

  always_comb begin
    sel_idx = idx_of(paddr);
    if (paddr[11:10] != 2'b00) begin
      sel_idx = 5'h1f;
    end
  end

  assign in_range = (sel_idx != 5'h1f);
  assign access = psel && penable && pready;
  assign wr_en = access && pwrite && in_range;
  // Soft reset is self-clearing: the write itself restores defaults
  assign soft_rst_req = wr_en && (sel_idx == 5'd0) && pwdata[pdpc_pkg::SOFT_RST_BIT];

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  // One wait state: ready is registered high at the end of the first access cycle, so it is high in the second
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && penable && !pready && !in_range;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (psel && penable && !pready && !pwrite && in_range) begin
      if (sel_idx == 5'd15) begin
        prdata <= {31'h0000_0000, soft_rst_seen_reg};
      end else if (sel_idx == 5'd14) begin
        prdata <= {31'h0000_0000, ramp_en_reg};
      end else begin
        prdata <= {24'h00_0000, regs[sel_idx[3:0]]};
      end
    end else if (!psel) begin
      prdata <= 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 14; g++) begin : g_reg
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          regs[g] <= reset_of(g);
        end else if (soft_rst_req) begin
          regs[g] <= reset_of(g);
        end else if (wr_en && sel_idx == 5'(g)) begin
          if (g == 0) begin
            regs[g] <= {5'h00, 1'b0, pwdata[1:0]};
          end else if (g == 3) begin
            regs[g] <= {1'b0, pwdata[6:0]};
          end else if (g == 12) begin
            regs[g] <= {3'h0, pwdata[4:2], 1'b0, pwdata[0]};
          end else if (g == 13) begin
            regs[g] <= {2'h0, pwdata[5:0]};
          end else begin
            regs[g] <= pwdata[7:0];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ramp_en_reg <= 1'b0;
    end else if (soft_rst_req) begin
      ramp_en_reg <= 1'b0;
    end else if (wr_en && sel_idx == 5'd14) begin
      ramp_en_reg <= pwdata[0];
    end
  end

  // Sticky status: set by soft reset, cleared by writing 1; set wins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      soft_rst_seen_reg <= 1'b0;
    end else if (soft_rst_req) begin
      soft_rst_seen_reg <= 1'b1;
    end else if (wr_en && sel_idx == 5'd15 && pwdata[0]) begin
      soft_rst_seen_reg <= 1'b0;
    end
  end

  // One-cycle pulse to the ramp engine
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ramp_start_reg <= 1'b0;
    end else begin
      ramp_start_reg <= wr_en && (sel_idx == 5'd1) && ramp_en_reg && !soft_rst_req;
    end
  end

  assign ramp_start = ramp_start_reg;
  assign ramp_enable = ramp_en_reg;

  // ----------------------------------------
  // Decoded configuration
  // ----------------------------------------
  pdpc_pkg::pdpc_cfg_s cfg_next;
  logic [1:0] pwr_code;
  logic [4:0] gain;

  // ----------------------------------------
  // Power-on view of the decoded configuration
  // ----------------------------------------
  // The analog side must never see an all-zero word: a zero reference divide and a
  // reserved minimum pulse would be illegal settings, so reset shows the defaults
  localparam pdpc_pkg::pdpc_cfg_s CFG_DEFAULT = '{
    powered: 1'b0,
    feedback_div: {pdpc_pkg::RST_FB_HIGH_MOD[1:0], pdpc_pkg::RST_FB_MID, pdpc_pkg::RST_FB_LOW},
    modulator_dither: pdpc_pkg::RST_FB_HIGH_MOD[pdpc_pkg::DITHER_LSB +: 2],
    modulator_order: pdpc_pkg::RST_FB_HIGH_MOD[pdpc_pkg::ORDER_LSB +: 3],
    order_reserved: 1'b0,
    fraction_numerator: {3{pdpc_pkg::RST_ZERO}},
    fraction_denominator: {1'b0, {3{pdpc_pkg::RST_ZERO}}},
    reference_div: {pdpc_pkg::RST_ZERO, pdpc_pkg::RST_REF_LOW},
    reference_bypass: 1'b1,
    reference_doubler_enable: pdpc_pkg::RST_REF_OPT[pdpc_pkg::DOUBLER_BIT],
    reference_divider_style: pdpc_pkg::RST_REF_OPT[pdpc_pkg::STYLE_BIT],
    pump_min_pulse: pdpc_pkg::RST_REF_OPT[pdpc_pkg::MIN_PULSE_LSB +: 2],
    pump_tristate: 1'b1,
    pump_current_ua: 12'h000,
    pump_polarity: pdpc_pkg::RST_PUMP[pdpc_pkg::POL_BIT]
  };

  always_comb begin
    pwr_code = regs[0][pdpc_pkg::PWR_SEL_LSB +: 2];
    gain = regs[13][pdpc_pkg::GAIN_LSB +: 5];
    cfg_next = '0;
    unique case (pdpc_pkg::pdpc_power_e'(pwr_code))
      pdpc_pkg::PDPC_PWR_DOWN: cfg_next.powered = 1'b0;
      pdpc_pkg::PDPC_PWR_UP: cfg_next.powered = 1'b1;
      pdpc_pkg::PDPC_PWR_PIN: cfg_next.powered = chip_enable;
      pdpc_pkg::PDPC_PWR_RSVD: cfg_next.powered = 1'b0;
    endcase
    // Range 16..262132 is software's duty; value passed unchanged
    cfg_next.feedback_div = {regs[3][1:0], regs[2], regs[1]};
    cfg_next.modulator_dither = regs[3][pdpc_pkg::DITHER_LSB +: 2];
    cfg_next.modulator_order = regs[3][pdpc_pkg::ORDER_LSB +: 3];
    cfg_next.order_reserved = regs[3][pdpc_pkg::ORDER_LSB +: 3] > 3'h4;
    cfg_next.fraction_numerator = {regs[6], regs[5], regs[4]};
    if (ramp_en_reg) begin
      cfg_next.fraction_denominator = pdpc_pkg::FIXED_DEN;
    end else begin
      cfg_next.fraction_denominator = {1'b0, regs[9], regs[8], regs[7]};
    end
    cfg_next.reference_div = {regs[11], regs[10]};
    cfg_next.reference_bypass = ({regs[11], regs[10]} == 16'h0001);
    cfg_next.reference_doubler_enable = regs[12][pdpc_pkg::DOUBLER_BIT];
    cfg_next.reference_divider_style = regs[12][pdpc_pkg::STYLE_BIT];
    cfg_next.pump_min_pulse = regs[12][pdpc_pkg::MIN_PULSE_LSB +: 2];
    cfg_next.pump_tristate = (gain == 5'h00);
    cfg_next.pump_current_ua = 12'(gain) * 12'h064;
    cfg_next.pump_polarity = regs[13][pdpc_pkg::POL_BIT];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg <= CFG_DEFAULT;
    end else begin
      cfg <= cfg_next;
    end
  end

endmodule
`default_nettype wire

// *** tb/pdpc_bank_asserts.sv ***
// Concurrent checks on the configuration bank ports
`timescale 1ns/1ps
`default_nettype none
module pdpc_bank_asserts (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire pdpc_pkg::pdpc_cfg_s cfg,
  input wire logic ramp_start,
  input wire logic ramp_enable
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  wire logic take = psel & penable & pready & pwrite;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_reset_dflt: assert property ($rose(rst_b) |=>
    cfg.feedback_div == 18'h0_0010 && cfg.reference_bypass && cfg.pump_min_pulse == 2'h1)
    else $error("defaults missing after reset");
  a_soft_rst: assert property (take && paddr == 12'h008 && pwdata[2] |=>
    !ramp_enable ##1 cfg.feedback_div == 18'h0_0010) else $error("soft reset ignored");
  a_ramp_cause: assert property (
    ramp_start == $past(take && paddr == 12'h040 && ramp_enable)) else $error("ramp start wrong");
  a_order_rsvd: assert property (
    cfg.order_reserved == (cfg.modulator_order > 3'h4)) else $error("order reserved flag wrong");
  a_den_fixed: assert property (ramp_enable && $past(ramp_enable) |->
    cfg.fraction_denominator == 25'h100_0000) else $error("denominator not fixed");
  a_ref_bypass: assert property (
    cfg.reference_bypass == (cfg.reference_div == 16'h0001)) else $error("bypass mismatch");
  a_gain_zero: assert property (cfg.pump_tristate |->
    cfg.pump_current_ua == 12'h000) else $error("tristate with current");
  a_gain_step: assert property (!cfg.pump_tristate |->
    cfg.pump_current_ua % 12'h064 == 12'h000 && cfg.pump_current_ua <= 12'hc1c
    && cfg.pump_current_ua != 12'h000) else $error("pump current off step");
endmodule
bind pdpc_bank pdpc_bank_asserts u_pdpc_bank_asserts (.clk, .rst_b, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .cfg, .ramp_start, .ramp_enable);
`default_nettype wire

// *** tb/pdpc_bank_tb.sv ***
// Self-checking bench for the configuration bank
`timescale 1ns/1ps
`default_nettype none
module pdpc_bank_tb;
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic chip_enable = 1'b0, pready, pslverr, ramp_start, ramp_enable, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  pdpc_pkg::pdpc_cfg_s cfg;
  int mismatches = 0, checks_done = 0, ramps = 0;
  logic [7:0] idx_t [14] = '{8'h02, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16,
    8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c};
  logic [7:0] rst_t [14] = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h01, 8'h00, 8'h08, 8'h00};
  logic [7:0] msk_t [14] = '{8'h03, 8'hff, 8'hff, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'h1d, 8'h3f};
  always #20 clk = ~clk;
  always @(posedge clk) if (ramp_start === 1'b1) ramps++;
  pdpc_bank u_pdpc_bank (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chip_enable(chip_enable), .cfg(cfg), .ramp_start(ramp_start),
    .ramp_enable(ramp_enable));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tally_and_finish;
    if (mismatches == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Holds the request until pready is sampled high at a rising edge, then waits
  // until cfg, launched one edge later, and the ramp pulse, launched at the sampling edge itself, have settled
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      mismatches++;
      tally_and_finish;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(negedge clk);
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(negedge clk);
    chk("cfg_dflt", 32'h000d_0001, 32'({cfg.reference_bypass, cfg.pump_tristate,
      cfg.pump_min_pulse, cfg.reference_div}));
    for (int i = 0; i < 14; i++) begin
      apb(1'b0, idx_t[i], 32'h0);
      chk("reset_val", {24'h0, rst_t[i]}, rd);
    end
    for (int i = 0; i < 14; i++) apb(1'b1, idx_t[i], 32'h0000_00fb);
    for (int i = 0; i < 14; i++) begin
      apb(1'b0, idx_t[i], 32'h0);
      chk("readback", {24'h0, 8'hfb & msk_t[i]}, rd);
    end
    chk("fb_div", 32'h0003_fbfb, 32'(cfg.feedback_div));
    chk("num", 32'h00fb_fbfb, 32'(cfg.fraction_numerator));
    chk("den", 32'h00fb_fbfb, 32'(cfg.fraction_denominator));
    for (int c = 0; c < 8; c++) begin
      @(posedge clk);
      chip_enable <= c[2];
      apb(1'b1, 8'h02, 32'(c[1:0]));
      chk("powered", 32'(c[1:0] == 2'h1 || (c[1:0] == 2'h2 && c[2])), 32'(cfg.powered));
    end
    for (int o = 0; o < 8; o++) begin
      apb(1'b1, 8'h12, 32'({o[2:0], o[1:0], 2'h0}));
      chk("order", 32'({cfg.order_reserved, cfg.modulator_order, cfg.modulator_dither}),
        32'({o > 4, o[2:0], o[1:0]}));
    end
    for (int g = 0; g < 32; g++) begin
      apb(1'b1, 8'h1c, 32'({g[0], g[4:0]}));
      chk("pump", 32'({cfg.pump_tristate, cfg.pump_current_ua, cfg.pump_polarity}),
        32'({g == 0, 12'(g * 100), g[0]}));
    end
    apb(1'b1, 8'h1a, 32'h0);
    for (int r = 1; r < 4; r++) begin
      apb(1'b1, 8'h19, 32'(r == 1 ? 1 : 4));
      apb(1'b1, 8'h1b, 32'({r[1:0], r[1], 1'b0, r[0]}));
      chk("ref_path", 32'({cfg.reference_doubler_enable, cfg.reference_divider_style,
        cfg.pump_min_pulse, cfg.reference_bypass, cfg.reference_div}),
        32'({r[0], r[1], r[1:0], r == 1, 16'(r == 1 ? 1 : 4)}));
    end
    apb(1'b1, 8'h10, 32'h0000_0020);
    chk("ramp_off", 32'h0, 32'(ramps));
    apb(1'b1, 8'h20, 32'h0000_0001);
    chk("den_fixed", 32'h0100_0000, 32'(cfg.fraction_denominator));
    apb(1'b1, 8'h10, 32'h0000_0030);
    apb(1'b1, 8'h11, 32'h0);
    chk("ramp_on", 32'h1, 32'(ramps));
    apb(1'b0, 8'h20, 32'h0);
    chk("ramp_ctrl", 32'h1, rd);
    apb(1'b0, 8'h05, 32'h0);
    chk("unmapped", 32'h1, {rd[30:0], err});
    apb(1'b1, 8'h02, 32'h0000_0004);
    apb(1'b0, 8'h10, 32'h0);
    chk("soft_rst", 32'h0000_0010, rd);
    chk("soft_rst_cfg", 32'h0000_0010, {13'h0, ramp_enable, cfg.feedback_div});
    apb(1'b0, 8'h21, 32'h0);
    chk("rst_seen", 32'h1, rd);
    apb(1'b1, 8'h21, 32'h1);
    apb(1'b0, 8'h21, 32'h0);
    chk("rst_seen_clr", 32'h0, rd);
    tally_and_finish;
  end
endmodule
`default_nettype wire
